// *** design/nested_irq_consts.svh ***
`ifndef NESTED_IRQ_CONSTS_SVH
`define NESTED_IRQ_CONSTS_SVH

// Vector count and source placement
`define NUM_VEC        14
`define NUM_EXT_GRP    3
`define PINS_PER_GRP   4
`define NUM_EXT_PIN    12
`define NUM_PERIPH     10
`define VEC_ESTOP      0
`define VEC_CLOCK      1
`define VEC_EXT0       2
`define VEC_PERIPH5    5

// Vector addresses at the top of memory
`define ADDR_RESET     16'hfffe
`define ADDR_TRAP      16'hfffc
`define ADDR_VEC0      16'hfffa

// Level codes held in the two level bits (high, low)
`define LVL_MAIN       2'b10
`define LVL_ONE        2'b01
`define LVL_TWO        2'b00
`define LVL_TOP        2'b11
`define LVL_HIGH_POS   5
`define LVL_LOW_POS    3

// Vectors that may leave halt mode
`define HALT_WAKE_MASK 14'h011e

// Register byte offsets
`define OFF_PRIO0      12'h000
`define OFF_PRIO1      12'h004
`define OFF_PRIO2      12'h008
`define OFF_PRIO3      12'h00c
`define OFF_CTRL       12'h010
`define OFF_EXT_SENSE  12'h014
`define OFF_PIN_EN     12'h018
`define OFF_PERIPH_EN  12'h01c
`define OFF_STATUS     12'h020

// Reset values and field positions
`define PRIO_RESET     8'hff
`define PRIO3_RO_MASK  8'hf0
`define CTRL_RESET     2'h0
`define CTRL_MASK_BIT  0
`define CTRL_EDGE_BIT  1
`define STAT_BUSY_BIT  2
`define STAT_PEND_LSB  16

// Sensitivity codes per external group
`define SENSE_LOW      2'h0
`define SENSE_RISE     2'h1
`define SENSE_FALL     2'h2
`define SENSE_BOTH     2'h3

`endif

// *** design/nested_irq_pkg.sv ***
package nested_irq_pkg;

  typedef enum logic [1:0] {
    ST_RESET_FETCH,
    ST_IDLE,
    ST_STACK
  } svc_state_e;

  // Events and levels coming from the CPU core
  typedef struct packed {
    logic       instr_done;
    logic       trap_exec;
    logic       ret_exec;
    logic [1:0] ret_level;
    logic       level_wr;
    logic [1:0] level_val;
    logic       stack_done;
    logic       halt_mode;
    logic       wait_mode;
  } cpu_ev_s;

  // Service requests towards the CPU core
  typedef struct packed {
    logic        stack_req;
    logic        fetch_req;
    logic [15:0] vec_addr;
    logic [1:0]  level;
    logic        wake;
  } svc_out_s;

endpackage

// *** design/nested_priority_interrupt_controller.sv ***
`timescale 1ns/1ps
`include "nested_irq_consts.svh"

// Summary of operation
// - Four nesting levels, fourteen vectors plus trap and reset at memory top.
// - Current level held as high bit 5 and low bit 3 of condition code.
// - Codes: main 10, level1 01, level2 00, level3 11; 11 masks maskables.
// - Service starts only at an instruction boundary.
// - Entry asks the core to push program counter, index, accumulator, condition code.
// - Maskable entry loads the level bits from the serviced vector's stored priority.
// - After stacking, the vector address is fetched as the routine start.
// - Return from interrupt restores the popped level bits.
// - Highest software priority wins; ties go to highest hardware priority.
// - Unserviced edge, stop and peripheral requests stay latched until they become the highest.
// - Reset, trap and emergency stop rank above every software priority.
// - Non-maskables ignore level; stack, vector, level 3 set; only trap wakes halt, emergency stop is blocked in halt.
// - Trap instruction follows the same flow as emergency stop.
// - Reset has top hardware priority and starts code at level 3.
// - Maskable taken only if enabled and its priority exceeds current level.
// - Emergency stop from chosen pin edge or speed error; held while pin low.
// - Edge external requests latch, clear on entry; sensitivity set by software.
// - Enabled pins sharing a line are ORed into one request.
// - Peripheral request needs both its flag and its enable bit.
// - Peripheral clear sequence resets the latch, dropping a pending request.
// - Any request wakes wait; only halt-capable ones wake halt.
// - After halt, first serviced is best halt-capable; others follow.
// - Writing code 10 into a priority field keeps the old field value.
module nested_priority_interrupt_controller
  import nested_irq_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     clk_en,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire cpu_ev_s                  cpu_ev,
  input  wire logic [`NUM_EXT_PIN-1:0]  ext_pin,
  input  wire logic                     estop_pin,
  input  wire logic                     speed_error,
  input  wire logic [`NUM_PERIPH-1:0]   periph_flag,
  input  wire logic [`NUM_PERIPH-1:0]   periph_clear,
  output svc_out_s                      svc
);

  // Register state
  logic [7:0]               prio_q [4];
  logic [1:0]               ctrl_q;
  logic [5:0]               sense_q;
  logic [`NUM_EXT_PIN-1:0]  pin_en_q;
  logic [`NUM_PERIPH-1:0]   periph_en_q;
  logic [1:0]               level_q;
  svc_state_e               state_q;
  logic [`NUM_EXT_PIN-1:0]  pin_prev_q;
  logic                     estop_prev_q;
  logic                     estop_lat_q;
  logic [`NUM_EXT_GRP-1:0]  ext_lat_q;
  logic [`NUM_PERIPH-1:0]   periph_lat_q;
  logic [15:0]              vec_q;
  logic [1:0]               new_level_q;

  // Halt-capable vectors as a named constant so single bits can be selected
  localparam logic [`NUM_VEC-1:0] halt_capable = `HALT_WAKE_MASK;

  // Combinational arbitration results
  logic [`NUM_VEC-1:0]      pend;
  logic [`NUM_EXT_GRP-1:0]  ext_req;
  logic                     estop_req;
  logic                     win;
  logic [3:0]               win_idx;
  logic [2:0]               win_rank;
  logic                     take;
  logic                     wr_en;
  logic                     rd_setup;

  // Level code to a plain rank, main lowest and level 3 highest
  function automatic logic [2:0] rank_of(input logic [1:0] code);
    case (code)
      `LVL_MAIN: rank_of = 3'd0;
      `LVL_ONE:  rank_of = 3'd1;
      `LVL_TWO:  rank_of = 3'd2;
      default:   rank_of = 3'd3;
    endcase
  endfunction

  // Stored two-bit priority of a maskable vector
  function automatic logic [1:0] prio_of(input logic [3:0] idx);
    logic [7:0] r;
    r = prio_q[idx[3:2]];
    prio_of = {r[{idx[1:0], 1'b1}], r[{idx[1:0], 1'b0}]};
  endfunction

  assign wr_en    = psel & penable & pready & pwrite;
  assign rd_setup = psel & ~penable;

  // Zero-wait slave: answer prepared in setup, ready in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= rd_setup;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (rd_setup) begin
        if (paddr == `OFF_PRIO0) begin
          prdata <= {24'h0, prio_q[0]};
        end else if (paddr == `OFF_PRIO1) begin
          prdata <= {24'h0, prio_q[1]};
        end else if (paddr == `OFF_PRIO2) begin
          prdata <= {24'h0, prio_q[2]};
        end else if (paddr == `OFF_PRIO3) begin
          prdata <= {24'h0, prio_q[3]};
        end else if (paddr == `OFF_CTRL) begin
          prdata <= {30'h0, ctrl_q};
        end else if (paddr == `OFF_EXT_SENSE) begin
          prdata <= {26'h0, sense_q};
        end else if (paddr == `OFF_PIN_EN) begin
          prdata <= {20'h0, pin_en_q};
        end else if (paddr == `OFF_PERIPH_EN) begin
          prdata <= {22'h0, periph_en_q};
        end else if (paddr == `OFF_STATUS) begin
          prdata <= {2'h0, pend, 13'h0, (state_q != ST_IDLE), level_q};
        end else begin
          pslverr <= 1'b1; // Unmapped offset
        end
      end
    end
  end

  // Priority registers, one field per vector
  genvar gr;
  generate
    for (gr = 0; gr < 4; gr++) begin : g_prio
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prio_q[gr] <= `PRIO_RESET;
        end else if (clk_en && wr_en && paddr == 12'(gr * 4)) begin
          for (int f = 0; f < 4; f++) begin
            // Main-level code is refused; the field keeps its value
            if (pwdata[2*f +: 2] != `LVL_MAIN) begin
              prio_q[gr][2*f +: 2] <= pwdata[2*f +: 2];
            end
          end
          if (gr == 3) begin
            prio_q[gr][7:4] <= 4'hf; // Upper nibble is read-only ones
          end
        end
      end
    end
  endgenerate

  // Control and enable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q      <= `CTRL_RESET;
      sense_q     <= 6'h0;
      pin_en_q    <= '0;
      periph_en_q <= '0;
    end else if (clk_en && wr_en) begin
      if (paddr == `OFF_CTRL) begin
        ctrl_q <= pwdata[1:0];
      end else if (paddr == `OFF_EXT_SENSE) begin
        sense_q <= pwdata[5:0];
      end else if (paddr == `OFF_PIN_EN) begin
        pin_en_q <= pwdata[`NUM_EXT_PIN-1:0];
      end else if (paddr == `OFF_PERIPH_EN) begin
        periph_en_q <= pwdata[`NUM_PERIPH-1:0];
      end
    end
  end

  // Previous pin levels for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_q   <= '1;
      estop_prev_q <= 1'b1;
    end else if (clk_en) begin
      pin_prev_q   <= ext_pin;
      estop_prev_q <= estop_pin;
    end
  end

  // External groups: enabled pins ORed, edge modes latched until entry
  genvar gg;
  generate
    for (gg = 0; gg < `NUM_EXT_GRP; gg++) begin : g_ext
      logic [`PINS_PER_GRP-1:0] en;
      logic [`PINS_PER_GRP-1:0] cur;
      logic [`PINS_PER_GRP-1:0] prv;
      logic [1:0]               mode;
      logic                     edge_hit;
      assign en   = pin_en_q[gg*`PINS_PER_GRP +: `PINS_PER_GRP];
      assign cur  = ext_pin[gg*`PINS_PER_GRP +: `PINS_PER_GRP];
      assign prv  = pin_prev_q[gg*`PINS_PER_GRP +: `PINS_PER_GRP];
      assign mode = sense_q[2*gg +: 2];
      always_comb begin
        case (mode)
          `SENSE_RISE: edge_hit = |(en & cur & ~prv);
          `SENSE_FALL: edge_hit = |(en & ~cur & prv);
          `SENSE_BOTH: edge_hit = |(en & (cur ^ prv));
          default:     edge_hit = 1'b0;
        endcase
      end
      // Low-level mode is a live request, never latched
      assign ext_req[gg] = (mode == `SENSE_LOW) ? |(en & ~cur) : ext_lat_q[gg];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ext_lat_q[gg] <= 1'b0;
        end else if (clk_en) begin
          // A new edge beats the clear of the same cycle
          if (edge_hit) begin
            ext_lat_q[gg] <= 1'b1;
          end else if (take && !cpu_ev.trap_exec && win_idx == 4'(`VEC_EXT0 + gg)) begin
            ext_lat_q[gg] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Peripheral latches: flag and enable needed, cleared by the clear sequence
  genvar gp;
  generate
    for (gp = 0; gp < `NUM_PERIPH; gp++) begin : g_periph
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          periph_lat_q[gp] <= 1'b0;
        end else if (clk_en) begin
          if (periph_flag[gp] && periph_en_q[gp]) begin
            periph_lat_q[gp] <= 1'b1;
          end else if (periph_clear[gp]) begin
            periph_lat_q[gp] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Emergency stop: chosen edge or speed error latched, pin low holds it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      estop_lat_q <= 1'b0;
    end else if (clk_en) begin
      if (speed_error ||
          (ctrl_q[`CTRL_EDGE_BIT] ? (estop_pin & ~estop_prev_q)
                                  : (~estop_pin & estop_prev_q))) begin
        estop_lat_q <= 1'b1;
      end else if (take && !cpu_ev.trap_exec && win_idx == 4'(`VEC_ESTOP)) begin
        estop_lat_q <= 1'b0;
      end
    end
  end

  assign estop_req = ctrl_q[`CTRL_MASK_BIT] & (estop_lat_q | ~estop_pin);

  // Pending vector map in hardware order, vector 0 highest
  always_comb begin
    pend                                    = '0;
    pend[`VEC_ESTOP]                        = estop_req;
    pend[`VEC_CLOCK]                        = periph_lat_q[0];
    pend[`VEC_EXT0 +: `NUM_EXT_GRP]         = ext_req;
    pend[`NUM_VEC-1:`VEC_PERIPH5]           = periph_lat_q[`NUM_PERIPH-1:1];
  end

  // Two-step decision: software rank first, then lowest vector number
  always_comb begin
    logic [2:0] r;
    logic       ok;
    r        = 3'd0;
    ok       = 1'b0;
    win      = 1'b0;
    win_idx  = 4'h0;
    win_rank = 3'd0;
    for (int v = `NUM_VEC - 1; v >= 0; v--) begin
      // Emergency stop ranks above every stored priority
      r  = (v == `VEC_ESTOP) ? 3'd4 : rank_of(prio_of(4'(v)));
      ok = pend[v] && ((v == `VEC_ESTOP) || r > rank_of(level_q));
      if (cpu_ev.halt_mode && !halt_capable[v]) begin
        ok = 1'b0;
      end
      if (ok && (!win || r >= win_rank)) begin
        win      = 1'b1;
        win_idx  = 4'(v);
        win_rank = r;
      end
    end
  end

  // Entry only at an instruction boundary, trap first
  assign take = (state_q == ST_IDLE) && cpu_ev.instr_done &&
                (cpu_ev.trap_exec || win);

  // Service sequencer: reset fetch, then idle, then stacking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= ST_RESET_FETCH;
      vec_q       <= `ADDR_RESET;
      new_level_q <= `LVL_TOP;
    end else if (clk_en) begin
      case (state_q)
        ST_RESET_FETCH: begin
          state_q <= ST_IDLE;
        end
        ST_IDLE: begin
          if (take) begin
            state_q <= ST_STACK;
            if (cpu_ev.trap_exec) begin
              vec_q       <= `ADDR_TRAP;
              new_level_q <= `LVL_TOP;
            end else if (win_idx == 4'(`VEC_ESTOP)) begin
              vec_q       <= `ADDR_VEC0;
              new_level_q <= `LVL_TOP;
            end else begin
              vec_q       <= `ADDR_VEC0 - {11'h0, win_idx, 1'b0};
              new_level_q <= prio_of(win_idx);
            end
          end
        end
        default: begin
          if (cpu_ev.stack_done) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Level bits: entry load, else return pop, else level instructions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= `LVL_TOP;
    end else if (clk_en) begin
      if (state_q == ST_STACK && cpu_ev.stack_done) begin
        level_q <= new_level_q;
      end else if (cpu_ev.ret_exec) begin
        level_q <= cpu_ev.ret_level;
      end else if (cpu_ev.level_wr) begin
        level_q <= cpu_ev.level_val;
      end
    end
  end

  // Registered service outputs towards the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      svc <= '{stack_req: 1'b0, fetch_req: 1'b0, vec_addr: `ADDR_RESET,
               level: `LVL_TOP, wake: 1'b0};
    end else if (clk_en) begin
      svc.stack_req <= (state_q == ST_IDLE) ? take
                       : (state_q == ST_STACK && !cpu_ev.stack_done);
      svc.fetch_req <= (state_q == ST_RESET_FETCH) ||
                       (state_q == ST_STACK && cpu_ev.stack_done);
      if (state_q == ST_IDLE && take) begin
        svc.vec_addr <= cpu_ev.trap_exec ? `ADDR_TRAP
                        : (`ADDR_VEC0 - {11'h0, win_idx, 1'b0});
      end else begin
        svc.vec_addr <= vec_q;
      end
      svc.level <= (state_q == ST_STACK && cpu_ev.stack_done) ? new_level_q
                   : cpu_ev.ret_exec ? cpu_ev.ret_level
                   : cpu_ev.level_wr ? cpu_ev.level_val : level_q;
      // Wait leaves on any request, halt only on halt-capable or trap
      svc.wake <= (cpu_ev.wait_mode && (|pend || cpu_ev.trap_exec)) ||
                  (cpu_ev.halt_mode &&
                   (|(pend & `HALT_WAKE_MASK) || cpu_ev.trap_exec));
    end
  end

endmodule

// *** verification/nested_irq_assertions.sv ***
`timescale 1ns/1ps
`include "nested_irq_consts.svh"

// Watches entry sequencing, level handling and bus answers
module nested_irq_checker
  import nested_irq_pkg::*;
(
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic [11:0] paddr,
  input logic        pready,
  input logic        pslverr,
  input cpu_ev_s     cpu_ev,
  input svc_out_s    svc
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Entry steps: boundary while idle, then stacking complete
  sequence s_take;
    cpu_ev.instr_done && !svc.stack_req && !svc.fetch_req;
  endsequence
  sequence s_stacked;
    svc.stack_req && cpu_ev.stack_done;
  endsequence

  a_stack_on_boundary: assert property (
    $rose(svc.stack_req) |-> $past(cpu_ev.instr_done))
    else $error("Stack request off an instruction boundary");
  a_trap_entry: assert property (
    s_take ##0 cpu_ev.trap_exec |=> svc.stack_req && svc.vec_addr == `ADDR_TRAP)
    else $error("Trap not entered at its boundary");
  a_stack_holds: assert property (
    svc.stack_req && !cpu_ev.stack_done |=> svc.stack_req && $stable(svc.vec_addr))
    else $error("Stack request dropped early");
  a_fetch_follows: assert property (
    s_stacked |=> svc.fetch_req && !svc.stack_req ##1 !svc.fetch_req)
    else $error("Vector fetch not one cycle after stacking");
  a_nmi_top_level: assert property (
    svc.fetch_req && svc.vec_addr inside {`ADDR_RESET, `ADDR_TRAP, `ADDR_VEC0}
    |-> svc.level == `LVL_TOP)
    else $error("Top source entered below level three");
  a_level3_masks: assert property (
    $rose(svc.stack_req) && $past(svc.level) == `LVL_TOP && !$past(cpu_ev.level_wr)
    && !$past(cpu_ev.ret_exec) |-> svc.vec_addr inside {`ADDR_TRAP, `ADDR_VEC0})
    else $error("Maskable source entered at level three");
  a_return_restore: assert property (
    cpu_ev.ret_exec && !cpu_ev.stack_done |=> svc.level == $past(cpu_ev.ret_level))
    else $error("Return did not restore level");
  a_level_write: assert property (
    cpu_ev.level_wr && !cpu_ev.ret_exec && !cpu_ev.stack_done
    |=> svc.level == $past(cpu_ev.level_val))
    else $error("Level write not applied");
  a_apb_answer: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("Bus answer not a single cycle");
  a_unmapped_err: assert property (
    psel && !penable && paddr > `OFF_STATUS |=> pready && pslverr)
    else $error("Unmapped access not refused");
endmodule

bind nested_priority_interrupt_controller nested_irq_checker u_chk (
  .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .cpu_ev, .svc
);

// *** verification/cpu_core_model.sv ***
`timescale 1ns/1ps

// Core side: instruction boundaries, stacking and level commands
module cpu_core_model
  import nested_irq_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire svc_out_s   svc,
  input  wire logic [3:0] stack_lat,
  input  wire logic       op_go,
  input  wire logic [1:0] op_kind,
  input  wire logic [1:0] op_lvl,
  input  wire logic       halt,
  input  wire logic       wait_in,
  output logic            op_busy,
  output cpu_ev_s         cpu_ev
);
  logic       done_q;
  logic       trap_q;
  logic       ret_q;
  logic       lvlw_q;
  logic [1:0] lvl_q;
  logic       stk_q;
  logic [3:0] cnt_q;
  logic       bnd;

  // Halted core reaches no boundary until woken; waiting core still does; none mid-entry
  assign bnd = !done_q && !svc.stack_req && !svc.fetch_req && (!halt || svc.wake);
  assign cpu_ev = cpu_ev_s'({done_q, trap_q, ret_q, lvl_q, lvlw_q, lvl_q, stk_q,
                             halt, wait_in});

  // Commands only issue with a boundary, as a real core would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q  <= 1'b0;
      trap_q  <= 1'b0;
      ret_q   <= 1'b0;
      lvlw_q  <= 1'b0;
      lvl_q   <= 2'b11;
      op_busy <= 1'b0;
    end else begin
      done_q  <= bnd;
      trap_q  <= bnd && op_busy && op_kind == 2'd1;
      ret_q   <= bnd && op_busy && op_kind == 2'd2;
      lvlw_q  <= bnd && op_busy && op_kind == 2'd3;
      lvl_q   <= op_lvl;
      op_busy <= op_go || (op_busy && !bnd);
    end
  end

  // Stacking takes a chosen number of cycles, slow or prompt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      stk_q <= 1'b0;
    end else begin
      cnt_q <= svc.stack_req ? cnt_q + 4'h1 : 4'h0;
      stk_q <= svc.stack_req && !stk_q && cnt_q == stack_lat;
    end
  end
endmodule

// *** verification/nested_priority_interrupt_controller_tb.sv ***
`timescale 1ns/1ps
`include "nested_irq_consts.svh"

module nested_priority_interrupt_controller_tb
  import nested_irq_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  cpu_ev_s     cpu_ev;
  svc_out_s    svc;
  logic [11:0] ext_pin;
  logic        estop_pin;
  logic [9:0]  periph_flag;
  logic [9:0]  periph_clear;
  logic [3:0]  stack_lat;
  logic        op_go;
  logic [1:0]  op_kind;
  logic [1:0]  op_lvl;
  logic        halt;
  logic        speed_error;
  logic        wait_in;
  logic        op_busy;
  logic [31:0] q;
  logic        e;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cycles = 0;

  nested_priority_interrupt_controller dut (
    .pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cpu_ev, .ext_pin, .estop_pin, .speed_error,
    .periph_flag, .periph_clear, .svc
  );
  cpu_core_model core (
    .pclk, .presetn, .svc, .stack_lat, .op_go, .op_kind, .op_lvl, .halt,
    .wait_in, .op_busy, .cpu_ev
  );

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One transfer; the idle edge at the end avoids double drives
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, q);
  endtask

  // Core command: 1 trap, 2 return, 3 level write
  task automatic op(input logic [1:0] k, input logic [1:0] l);
    op_kind <= k;
    op_lvl  <= l;
    op_go   <= 1'b1;
    @(posedge pclk);
    op_go <= 1'b0;
    @(posedge pclk);
    while (op_busy !== 1'b0) begin
      @(posedge pclk);
    end
  endtask

  // Waits for the fetch, then checks vector and loaded level
  task automatic entry(input string nm, input logic [15:0] av, input logic [1:0] lv);
    int n;
    n = 0;
    while (svc.fetch_req !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk(nm, {13'h0, 1'b1, lv, av}, {13'h0, svc.fetch_req, svc.level, svc.vec_addr});
    @(posedge pclk);
  endtask

  task automatic quiet(input string nm);
    logic seen;
    seen = 1'b0;
    repeat (30) begin
      @(posedge pclk);
      seen = seen | svc.stack_req;
    end
    chk(nm, 32'h0, {31'h0, seen});
  endtask

  task automatic clr(input int i);
    periph_flag[i]  <= 1'b0;
    periph_clear[i] <= 1'b1;
    @(posedge pclk);
    periph_clear[i] <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, periph_flag, periph_clear} = '0;
    {stack_lat, op_go, op_kind, op_lvl, halt, speed_error, wait_in} = '0;
    ext_pin = '1;
    estop_pin = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rd("prio0 reset", `OFF_PRIO0, 32'hff);
    wr(`OFF_PRIO3, 32'h0);
    rd("prio3 upper fixed", `OFF_PRIO3, 32'hf0);
    wr(`OFF_PRIO0, 32'h64);
    rd("prio0 level0 kept", `OFF_PRIO0, 32'h74);
    rd("status after reset", `OFF_STATUS, 32'h3);
    apb(1'b0, 12'h024, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    $display("test registers done");
    // Vectors 5,6,7 at levels 1,2,1
    wr(`OFF_PRIO1, 32'h47);
    wr(`OFF_PERIPH_EN, 32'h0e);
    op(2'd3, `LVL_MAIN);
    periph_flag <= 10'h00e;
    entry("software priority", 16'hffee, `LVL_TWO);
    quiet("lower level waits");
    clr(2);
    op(2'd2, `LVL_MAIN);
    entry("hardware tie break", 16'hfff0, `LVL_ONE);
    quiet("equal level waits");
    clr(1);
    op(2'd2, `LVL_MAIN);
    entry("latched request", 16'hffec, `LVL_ONE);
    clr(3);
    op(2'd2, `LVL_MAIN);
    $display("test arbitration done");
    op(2'd3, `LVL_TOP);
    periph_flag <= 10'h002;
    wait_in     <= 1'b1;
    quiet("level three masks");
    chk("wait left", 32'h1, {31'h0, svc.wake});
    wait_in <= 1'b0;
    op(2'd1, 2'b00);
    entry("trap at level three", `ADDR_TRAP, `LVL_TOP);
    wr(`OFF_CTRL, 32'h1);
    estop_pin <= 1'b0;
    repeat (2) @(posedge pclk);
    estop_pin <= 1'b1;
    entry("stop edge latched", `ADDR_VEC0, `LVL_TOP);
    op(2'd2, `LVL_TOP);
    op(2'd2, `LVL_MAIN);
    entry("masked one later", 16'hfff0, `LVL_ONE);
    clr(1);
    op(2'd3, `LVL_TOP);
    periph_flag <= 10'h004;
    repeat (2) @(posedge pclk);
    clr(2);
    op(2'd3, `LVL_MAIN);
    quiet("cleared pending lost");
    speed_error <= 1'b1;
    @(posedge pclk);
    speed_error <= 1'b0;
    entry("speed error stop", `ADDR_VEC0, `LVL_TOP);
    op(2'd2, `LVL_MAIN);
    $display("test top sources done");
    wr(`OFF_EXT_SENSE, 32'h2);
    wr(`OFF_PIN_EN, 32'h00f);
    ext_pin[1] <= 1'b0;
    entry("falling pin", 16'hfff6, `LVL_TOP);
    op(2'd2, `LVL_MAIN);
    quiet("edge cleared on entry");
    wr(`OFF_PIN_EN, 32'h008);
    ext_pin[3] <= 1'b0;
    entry("other enabled pin", 16'hfff6, `LVL_TOP);
    op(2'd2, `LVL_MAIN);
    wr(`OFF_EXT_SENSE, 32'h1);
    ext_pin[3] <= 1'b1;
    entry("rising pin", 16'hfff6, `LVL_TOP);
    op(2'd2, `LVL_MAIN);
    $display("test external done");
    // Vector 5 outranks vector 8, only 8 may leave halt
    wr(`OFF_PRIO1, 32'h43);
    wr(`OFF_PRIO2, 32'hfd);
    wr(`OFF_PERIPH_EN, 32'h01e);
    stack_lat <= 4'd5;
    halt <= 1'b1;
    periph_flag <= 10'h002;
    quiet("halt not left");
    chk("no wake", 32'h0, {31'h0, svc.wake});
    periph_flag <= 10'h012;
    entry("halt capable first", 16'hffea, `LVL_ONE);
    halt <= 1'b0;
    entry("held one next", 16'hfff0, `LVL_TWO);
    $display("test halt done");
    tally_and_finish();
  end
endmodule
